// File: hw/umf_modem_flow.sv
/*
  modem status, scratchpad, divisor, identity and enhanced feature logic
  of a small uart. assumes the receiver, transmitter and fifo cores sit
  beside it and an avalon-mm master with waitrequest reaches the registers.
*/
// Overview of operation
// [R1] data-set-ready change sets its delta flag; modem irq if enable bit 3.
// [R2] ring delta set only when ring pin rises 0 to 1.
// [R3] carrier-detect change sets its delta flag; modem irq if enabled.
// [R4] auto clear-to-send halts transmit after current character, resumes when low.
// [R5] clear-to-send status is inverted pin, or rts control bit in loopback.
// [R6] data-set-ready status is inverted pin, or dtr control bit in loopback.
// [R7] ring status is inverted pin, or modem control bit 2 in loopback.
// [R8] carrier status is inverted pin, or modem control bit 3 in loopback.
// [R9] eight-bit scratchpad, read/write, all ones after reset.
// [R10] sixteen-bit divisor; bit rate is prescaled clock over 16 over divisor.
// [R11] read-only identification code; software zeroes divisor first.
// [R12] read-only revision code; software zeroes divisor first.
// [R13] enhanced bits 3:2 select transmit flow characters: none, first, second, both.
// [R14] enhanced bits 1:0 select receive compare; 11 means either or sequence.
// [R15] dual modes treat two characters as one consecutive sequence; code matches either one when bits 3:2 are 10 or 01.
// [R16] software clears flow select bits before programming a new setting.
// [R17] enhanced enable gates writes to high enable, status, fifo, control bits.
// [R18] reset clears every gated enhanced bit.
// [R19] special detect compares each character with second pause, stores, flags.
// [R20] second-pair compare with special detect: no store, pause and special irq.
// [R21] auto rts: irq at trigger, deassert one level above, reassert one below.
// [R22] auto rts needs rts control bit; otherwise pin is plain output.
// [R23] modem control bit 4 enables internal loopback.
// [R24] modem control bit 7 selects divide-by-four prescaler.
// [R25] reading modem status clears the four delta flags.
`timescale 1ns/1ps
module umf_modem_flow
  import umf_pkg::*;
#(
  parameter logic [7:0] IDENT_CODE = 8'h3c,  // arbitrary value
  parameter logic [7:0] REV_CODE   = 8'h02   // arbitrary value
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // modem pins
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ring_indicator_n,
  input  wire logic        carrier_detect_n,
  output logic             rts_n,
  output logic             dtr_n,
  // transmitter side
  input  wire logic        tx_busy,
  output logic             tx_halt,
  output logic      [1:0]  tx_flow_mode,
  output logic      [15:0] tx_resume_chars,
  output logic      [15:0] tx_pause_chars,
  output logic             baud_x16_tick,
  // receiver side
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic [4:0]  rx_level,
  input  wire logic [4:0]  rx_trig_level,
  input  wire logic [4:0]  rx_trig_above,
  input  wire logic [4:0]  rx_trig_below,
  output logic             rx_push,
  output logic      [7:0]  rx_push_data,
  output logic             rx_resume_det,
  output logic             rx_pause_det,
  output logic             special_det,
  // requests and settings for neighbours
  output logic             modem_irq,
  output logic             special_irq,
  output logic             pause_irq,
  output logic             rx_trig_irq,
  output logic      [7:0]  int_enable,
  output logic      [7:0]  modem_ctrl,
  output logic      [1:0]  fifo_ctrl_enh
);
  // ==========================================================
  // reset release and pin synchronisers
  logic       rst_sync_b;
  logic [3:0] pins_s;
  umf_sync #(.W(1), .INIT(1'b0)) u_rst_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (1'b1),
    .q     (rst_sync_b)
  );
  umf_sync #(.W(4), .INIT(4'hf)) u_pin_sync (
    .clock (clock),
    .rst_b (rst_sync_b),
    .d     ({carrier_detect_n, ring_indicator_n, dsr_n, cts_n}),
    .q     (pins_s)
  );
  // ==========================================================
  // decoded terms
  umf_state_t s;
  umf_state_t n;
  logic [3:0] stat;
  logic       done;
  logic       wr;
  logic       rd_msr;
  logic       rd_isr;
  logic [7:0] wd;
  logic       enh;

  assign wd     = avs_writedata[7:0];
  assign done   = (s.st == BUS_ACK);
  assign wr     = done & avs_write & avs_byteenable[0];
  assign rd_msr = done & avs_read & (avs_address == ADR_MODEM_STATUS);
  assign rd_isr = done & avs_read & (avs_address == ADR_INT_STATUS);
  assign enh    = s.enhanced_features[EFR_ENH_EN];
  // order {cd, ri, dsr, cts}
  // [R5] [R6] [R7] [R8] [R23] loopback source select
  assign stat = s.modem_control[MCR_LOOP] ?
                {s.modem_control[MCR_OUT2], s.modem_control[MCR_OUT1], s.modem_control[MCR_DTR], s.modem_control[MCR_RTS]} :
                ~pins_s;
  // one wait cycle on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~done;
  // ==========================================================
  // next state
  always_comb
  begin
    logic [7:0] rmux;
    logic [3:0] chg;
    logic       pre_tick;
    logic       m_on1;
    logic       m_on2;
    logic       m_off1;
    logic       m_off2;
    logic       f_on;
    logic       f_off;
    logic       seq_mode;
    logic       spec;
    rmux     = RST_ZERO;
    chg      = 4'h0;
    pre_tick = 1'b0;
    f_on     = 1'b0;
    f_off    = 1'b0;
    seq_mode = 1'b0;
    n        = s;
    unique case (s.st)
      BUS_IDLE: if (avs_read | avs_write) n.st = BUS_ACK;
      BUS_ACK:  n.st = BUS_IDLE;
    endcase
    case (avs_address)
      ADR_MODEM_STATUS:  rmux = {stat, s.delta};
      ADR_SCRATCHPAD:    rmux = s.scratchpad;
      ADR_DIVISOR_LOW:   rmux = s.div[7:0];
      ADR_DIVISOR_HIGH:  rmux = s.div[15:8];
      // [R11] [R12] read-only identity
      ADR_DEVICE_IDENT:  rmux = IDENT_CODE;
      ADR_DEVICE_REV:    rmux = REV_CODE;
      ADR_ENH_FEATURES:  rmux = s.enhanced_features;
      ADR_INT_ENABLE:    rmux = s.interrupt_enable;
      ADR_MODEM_CONTROL: rmux = s.modem_control;
      ADR_FIFO_CONTROL:  rmux = {2'b00, s.fcr_enh, 4'h0};
      ADR_INT_STATUS:    rmux = {2'b00, s.isr_enh[1],
                                 s.isr_enh[0] | s.spec_flag | s.pause_flag, 4'h0};
      ADR_RESUME_FIRST:  rmux = s.on1;
      ADR_RESUME_SECOND: rmux = s.on2;
      ADR_PAUSE_FIRST:   rmux = s.off1;
      ADR_PAUSE_SECOND:  rmux = s.off2;
      default:           rmux = RST_ZERO;
    endcase
    if (s.st == BUS_IDLE && avs_read)
      n.rdata = rmux;
    // writes take effect at the edge that samples waitrequest low
    if (wr)
    begin
      case (avs_address)
        // [R9] scratchpad store
        ADR_SCRATCHPAD:    n.scratchpad = wd;
        ADR_DIVISOR_LOW:   n.div[7:0] = wd;
        ADR_DIVISOR_HIGH:  n.div[15:8] = wd;
        ADR_ENH_FEATURES:  n.enhanced_features = wd;
        ADR_RESUME_FIRST:  n.on1 = wd;
        ADR_RESUME_SECOND: n.on2 = wd;
        ADR_PAUSE_FIRST:   n.off1 = wd;
        ADR_PAUSE_SECOND:  n.off2 = wd;
        // [R17] enhanced bits move only while enabled
        ADR_INT_ENABLE:
        begin
          n.interrupt_enable[3:0] = wd[3:0];
          if (enh) n.interrupt_enable[7:4] = wd[7:4];
        end
        ADR_MODEM_CONTROL:
        begin
          n.modem_control[1:0] = wd[1:0];
          n.modem_control[4:3] = wd[4:3];
          if (enh) n.modem_control[2] = wd[2];
          if (enh) n.modem_control[7:5] = wd[7:5];
        end
        ADR_FIFO_CONTROL:  if (enh) n.fcr_enh = wd[5:4];
        ADR_INT_STATUS:    if (enh) n.isr_enh = wd[5:4];
        default:           n.scratchpad = s.scratchpad;
      endcase
    end
    // ========================================================
    // modem deltas
    // [R1] [R3] any change of dsr or cd, cts too
    chg[0] = stat[0] ^ s.prev[0];
    chg[1] = stat[1] ^ s.prev[1];
    chg[3] = stat[3] ^ s.prev[3];
    // [R2] pin rising means status bit falling
    chg[2] = s.prev[2] & ~stat[2];
    n.prev = stat;
    // [R25] read clears, a change in the same cycle still lands
    n.delta = (rd_msr ? 4'h0 : s.delta) | chg;
    // ========================================================
    // baud generator
    // [R24] divide by four when selected
    pre_tick  = ~s.modem_control[MCR_PRESCALE] | (s.pre_cnt == PRESCALE_MAX);
    n.pre_cnt = s.modem_control[MCR_PRESCALE] ? s.pre_cnt + 2'h1 : 2'h0;
    // [R10] 16x tick every divisor prescaled clocks; divisor 0 stops it
    n.tick = 1'b0;
    if (pre_tick)
    begin
      if (s.div != 16'h0000 && s.baud_cnt >= s.div - 16'h0001)
      begin
        n.baud_cnt = 16'h0000;
        n.tick     = 1'b1;
      end
      else
        n.baud_cnt = s.baud_cnt + 16'h0001;
    end
    // ========================================================
    // receive character compare
    m_on1  = (rx_data == s.on1);
    m_on2  = (rx_data == s.on2);
    m_off1 = (rx_data == s.off1);
    m_off2 = (rx_data == s.off2);
    // [R14] receive compare modes
    case (s.enhanced_features[1:0])
      2'b10:
      begin
        f_on  = m_on1;
        f_off = m_off1;
      end
      2'b01:
      begin
        f_on  = m_on2;
        f_off = m_off2;
      end
      2'b11:
        if (s.enhanced_features[3:2] == 2'b10 || s.enhanced_features[3:2] == 2'b01)
        begin
          f_on  = m_on1 | m_on2;
          f_off = m_off1 | m_off2;
        end
        else
        begin
          // [R15] first then second, consecutive
          seq_mode = 1'b1;
          f_on     = s.seq_on & m_on2;
          f_off    = s.seq_off & m_off2;
        end
      default:
      begin
        f_on  = 1'b0;
        f_off = 1'b0;
      end
    endcase
    if (rx_valid)
    begin
      n.seq_on  = seq_mode & m_on1;
      n.seq_off = seq_mode & m_off1;
    end
    // [R19] special match on second pause character
    spec = rx_valid & s.enhanced_features[EFR_SPECIAL] & m_off2;
    // the first half of a sequence is stored; only the closing one is dropped
    // [R20] a flow match never enters the fifo
    n.push      = rx_valid & ~(f_on | f_off);
    n.push_data = rx_data;
    n.resume    = rx_valid & (f_on | s.modem_control[MCR_ANY]);
    n.pause     = rx_valid & f_off;
    n.special   = spec;
    n.spec_flag  = (rd_isr ? 1'b0 : s.spec_flag) | spec;
    n.pause_flag = (rd_isr ? 1'b0 : s.pause_flag) | (rx_valid & f_off);
    // ========================================================
    // hardware flow control
    // [R4] stop only once the character in flight is done
    if (!(s.enhanced_features[EFR_AUTO_CTS] & ~stat[0]))
      n.halt = 1'b0;
    else if (!tx_busy)
      n.halt = 1'b1;
    // [R21] [R22] hysteresis, armed by the rts control bit
    if (!(s.enhanced_features[EFR_AUTO_RTS] & s.modem_control[MCR_RTS]))
      n.rts_full = 1'b0;
    else if (rx_level >= rx_trig_above)
      n.rts_full = 1'b1;
    else if (rx_level < rx_trig_below)
      n.rts_full = 1'b0;
    n.trig_irq = s.enhanced_features[EFR_AUTO_RTS] & (rx_level >= rx_trig_level);
    // loopback keeps the outputs inactive
    n.rts_n = s.modem_control[MCR_LOOP] | ~(s.modem_control[MCR_RTS] & ~s.rts_full);
    n.dtr_n = s.modem_control[MCR_LOOP] | ~s.modem_control[MCR_DTR];
  end
  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      s          <= '0;
      s.st       <= BUS_IDLE;
      s.scratchpad      <= RST_SCRATCH;
      // [R18] gated enhanced bits clear
      s.div      <= RST_DIVISOR;
      s.rts_n    <= 1'b1;
      s.dtr_n    <= 1'b1;
    end
    else
      s <= n;
  end
  // ==========================================================
  // outputs
  assign avs_readdata    = {24'h000000, s.rdata};
  assign rts_n           = s.rts_n;
  assign dtr_n           = s.dtr_n;
  assign tx_halt         = s.halt;
  // [R13] transmit character selection
  assign tx_flow_mode    = s.enhanced_features[3:2];
  assign tx_resume_chars = {s.on1, s.on2};
  assign tx_pause_chars  = {s.off1, s.off2};
  assign baud_x16_tick   = s.tick;
  assign rx_push         = s.push;
  assign rx_push_data    = s.push_data;
  assign rx_resume_det   = s.resume;
  assign rx_pause_det    = s.pause;
  assign special_det     = s.special;
  assign modem_irq       = s.interrupt_enable[IER_MODEM] & (|s.delta);
  assign special_irq     = s.interrupt_enable[IER_SPECIAL] & s.spec_flag;
  assign pause_irq       = s.interrupt_enable[IER_SPECIAL] & s.pause_flag;
  assign rx_trig_irq     = s.trig_irq;
  assign int_enable      = s.interrupt_enable;
  assign modem_ctrl      = s.modem_control;
  assign fifo_ctrl_enh   = s.fcr_enh;
  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);
  sequence msr_read_s;
    (s.st == BUS_IDLE) && avs_read && (avs_address == ADR_MODEM_STATUS);
  endsequence
  sequence loop_read_s;
    msr_read_s ##0 s.modem_control[MCR_LOOP] && (n.modem_control == s.modem_control);
  endsequence
  a_dsr_delta:   assert property ((stat[1] != s.prev[1]) |=> s.delta[1]) // [R1]
    else $error("dsr change not flagged");
  a_ring_edge:   assert property (!s.delta[2] && !(s.prev[2] && !stat[2]) |=> !s.delta[2]) // [R2]
    else $error("ring delta set without rising pin");
  a_cd_delta:    assert property ((stat[3] != s.prev[3]) |=> s.delta[3]) // [R3]
    else $error("cd change not flagged");
  a_cts_halt:    assert property (s.enhanced_features[EFR_AUTO_CTS] && !stat[0] && !tx_busy
    && (n.enhanced_features == s.enhanced_features) |=> tx_halt) // [R4]
    else $error("transmit not halted");
  a_loop_cts:    assert property (loop_read_s |=> avs_readdata[4] == $past(s.modem_control[MCR_RTS])) // [R5]
    else $error("loopback cts wrong");
  a_scratch_wr:  assert property (wr && avs_address == ADR_SCRATCHPAD
    |=> s.scratchpad == $past(wd)) // [R9]
    else $error("scratchpad not written");
  a_enh_gate:    assert property (wr && !enh && avs_address == ADR_INT_ENABLE
    |=> s.interrupt_enable[7:4] == $past(s.interrupt_enable[7:4])) // [R17]
    else $error("gated enable bits changed");
  a_rts_auto:    assert property (s.enhanced_features[EFR_AUTO_RTS] && s.modem_control[MCR_RTS] && !s.modem_control[MCR_LOOP]
    && rx_level >= rx_trig_above && !wr ##1 !wr |=> rts_n) // [R21]
    else $error("rts not deasserted above level");
  a_msr_clear:   assert property (msr_read_s ##1 (rd_msr && stat == s.prev)
    |=> s.delta == 4'h0) // [R25]
    else $error("delta flags not cleared");
endmodule

// File: hw/umf_pkg.sv
/*
  constants, register map and state types for the modem status and
  flow control block. assumes a 32-bit avalon-mm slave, one register
  per aligned word, data in the low byte.
*/
package umf_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [5:0] ADR_MODEM_STATUS   = 6'h00;
  localparam logic [5:0] ADR_SCRATCHPAD     = 6'h04;
  localparam logic [5:0] ADR_DIVISOR_LOW    = 6'h08;
  localparam logic [5:0] ADR_DIVISOR_HIGH   = 6'h0c;
  localparam logic [5:0] ADR_DEVICE_IDENT   = 6'h10;
  localparam logic [5:0] ADR_DEVICE_REV     = 6'h14;
  localparam logic [5:0] ADR_ENH_FEATURES   = 6'h18;
  localparam logic [5:0] ADR_INT_ENABLE     = 6'h1c;
  localparam logic [5:0] ADR_MODEM_CONTROL  = 6'h20;
  localparam logic [5:0] ADR_FIFO_CONTROL   = 6'h24;
  localparam logic [5:0] ADR_INT_STATUS     = 6'h28;
  localparam logic [5:0] ADR_RESUME_FIRST   = 6'h2c;
  localparam logic [5:0] ADR_RESUME_SECOND  = 6'h30;
  localparam logic [5:0] ADR_PAUSE_FIRST    = 6'h34;
  localparam logic [5:0] ADR_PAUSE_SECOND   = 6'h38;
  // ==========================================================
  // field positions
  localparam int EFR_ENH_EN   = 4;
  localparam int EFR_SPECIAL  = 5;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int MCR_DTR      = 0;
  localparam int MCR_RTS      = 1;
  localparam int MCR_OUT1     = 2;
  localparam int MCR_OUT2     = 3;
  localparam int MCR_LOOP     = 4;
  localparam int MCR_ANY      = 5;
  localparam int MCR_PRESCALE = 7;
  localparam int IER_MODEM    = 3;
  localparam int IER_SPECIAL  = 5;
  localparam int ISR_SPECIAL  = 4;
  // ==========================================================
  // reset values and counts
  localparam logic [7:0]  RST_SCRATCH  = 8'hff;
  localparam logic [15:0] RST_DIVISOR  = 16'h0001;
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [1:0]  PRESCALE_MAX = 2'h3;
  // ==========================================================
  // bus state and block state
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} umf_bus_t;
  typedef struct packed {
    umf_bus_t    st;
    logic [7:0]  rdata;
    logic [3:0]  delta;
    logic [3:0]  prev;
    logic [7:0]  scratchpad;
    logic [15:0] div;
    logic [7:0]  enhanced_features;
    logic [7:0]  interrupt_enable;
    logic [7:0]  modem_control;
    logic [1:0]  fcr_enh;
    logic [1:0]  isr_enh;
    logic [7:0]  on1;
    logic [7:0]  on2;
    logic [7:0]  off1;
    logic [7:0]  off2;
    logic [1:0]  pre_cnt;
    logic [15:0] baud_cnt;
    logic        tick;
    logic        seq_on;
    logic        seq_off;
    logic        push;
    logic [7:0]  push_data;
    logic        resume;
    logic        pause;
    logic        special;
    logic        spec_flag;
    logic        pause_flag;
    logic        halt;
    logic        rts_full;
    logic        trig_irq;
    logic        rts_n;
    logic        dtr_n;
  } umf_state_t;
endpackage

// File: hw/umf_sync.sv
/*
  two flip-flop synchroniser with a chosen reset value.
  assumes d is asynchronous to clock; only q may be read.
*/
`timescale 1ns/1ps
module umf_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= INIT;
      q      <= INIT;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: dv/umf_modem_model.sv
/*
  modem at the far end of the handshake lines.
  assumes the bench calls set_lines from one process only.
*/
`timescale 1ns/1ps
module umf_modem_model (
  // clock
  input  wire logic clock,
  // terminal outputs seen by the modem
  input  wire logic rts_n,
  input  wire logic dtr_n,
  // modem outputs, idle high
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ring_indicator_n,
  output logic      carrier_detect_n
);
  logic [3:0] lines_r = 4'hf;
  // ==========================================================
  // line order: carrier, ring, dsr, cts
  assign {carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = lines_r;
  // slow answers wait n + 1 edges before the lines move
  task automatic set_lines(input logic [3:0] v, input int n);
    repeat (n + 1) @(posedge clock);
    lines_r <= v;
  endtask
  function automatic logic [1:0] peer_req();
    return {~dtr_n, ~rts_n};
  endfunction
endmodule

// File: dv/tb_umf_modem_flow.sv
/*
  register-level bench for the modem status and flow control block.
  assumes the avalon slave answers after one wait cycle.
*/
`timescale 1ns/1ps
module tb_umf_modem_flow;
  import umf_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, cts_n, dsr_n, ring_indicator_n, carrier_detect_n;
  logic rts_n, dtr_n, tx_busy = 1'b0, tx_halt, baud_x16_tick, rx_valid = 1'b0;
  logic [1:0] tx_flow_mode;
  logic [15:0] tx_resume_chars, tx_pause_chars;
  logic [7:0] rx_data = 8'h0, rx_push_data, int_enable, modem_ctrl, q_r, rdq;
  logic [4:0] rx_level = 5'h0, rx_trig_level = 5'h08;
  logic [4:0] rx_trig_above = 5'h0c, rx_trig_below = 5'h04;
  logic rx_push, rx_resume_det, rx_pause_det, special_det, ws;
  logic modem_irq, special_irq, pause_irq, rx_trig_irq;
  logic [1:0] fifo_ctrl_enh;
  int err_total = 0, checks = 0, cyc = 0;
  // ident and revision values are arbitrary
  umf_modem_flow #(.IDENT_CODE(8'h5a), .REV_CODE(8'ha5)) i_dut (
    .clock, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cts_n, .dsr_n,
    .ring_indicator_n, .carrier_detect_n, .rts_n, .dtr_n, .tx_busy, .tx_halt,
    .tx_flow_mode, .tx_resume_chars, .tx_pause_chars, .baud_x16_tick,
    .rx_valid, .rx_data, .rx_level, .rx_trig_level, .rx_trig_above,
    .rx_trig_below, .rx_push, .rx_push_data, .rx_resume_det, .rx_pause_det,
    .special_det, .modem_irq, .special_irq, .pause_irq, .rx_trig_irq,
    .int_enable, .modem_ctrl, .fifo_ctrl_enh);
  umf_modem_model i_modem (.clock, .rts_n, .dtr_n, .cts_n, .dsr_n,
    .ring_indicator_n, .carrier_detect_n);
  // ==========================================================
  // clock, bus sampling, timeout
  initial forever #10 clock = ~clock;
  // values seen just before each rising edge
  always @(negedge clock)
  begin
    ws  = avs_waitrequest;
    rdq = avs_readdata[7:0];
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end
  // ==========================================================
  // tasks
  task automatic print_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h0, d};
    do @(posedge clock); while (ws !== 1'b0);
    q_r = rdq;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e, input string m);
    bus(1'b0, a, 8'h00);
    chk(q_r, e, m);
  endtask
  task automatic do_reset();
    @(posedge clock) rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  // pulses are registered: look half a cycle after the taking edge
  task automatic rx(input logic [7:0] c, input logic [3:0] e, input string m);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data  <= c;
    @(posedge clock) rx_valid <= 1'b0;
    @(negedge clock);
    chk({4'h0, rx_push, rx_resume_det, rx_pause_det, special_det}, {4'h0, e}, m);
    if (e[3])
      chk(rx_push_data, c, "push data");
  endtask
  task automatic period(input logic [7:0] e, input string m);
    logic [7:0] n;
    n = 8'h00;
    repeat (40) @(negedge clock);
    @(negedge clock iff baud_x16_tick === 1'b1);
    do begin @(negedge clock); n++; end while (baud_x16_tick !== 1'b1 && n < 8'hff);
    chk(n, e, m);
  endtask
  // ==========================================================
  // tests
  initial
  begin
    logic [7:0] ef [9] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h0b, 8'h0b, 8'h0f, 8'h22, 8'h21};
    logic [7:0] ch [9] = '{8'h13, 8'h14, 8'h14, 8'h12, 8'h12, 8'h13, 8'h13, 8'h14, 8'h14};
    logic [3:0] ex [9] = '{4'h2, 4'h8, 4'h2, 4'h4, 4'h4, 4'h2, 4'h8, 4'h9, 4'h3};
    logic [4:0] lv [4] = '{5'h08, 5'h0c, 5'h05, 5'h03};
    logic [1:0] rx2 [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    do_reset();
    rdchk(ADR_SCRATCHPAD, 8'hff, "spr reset");
    rdchk(6'h3c, 8'h00, "unmapped");
    wr(ADR_SCRATCHPAD, 8'h5c);
    avs_byteenable <= 4'he;
    wr(ADR_SCRATCHPAD, 8'h00);
    avs_byteenable <= 4'hf;
    rdchk(ADR_SCRATCHPAD, 8'h5c, "spr rw");
    rdchk(ADR_DIVISOR_LOW, 8'h01, "dll reset");
    rdchk(ADR_DIVISOR_HIGH, 8'h00, "dlm reset");
    // divisor zeroed before the identity reads
    wr(ADR_DIVISOR_LOW, 8'h00);
    wr(ADR_DIVISOR_HIGH, 8'h00);
    wr(ADR_DEVICE_IDENT, 8'h00);
    rdchk(ADR_DEVICE_IDENT, 8'h5a, "ident ro");
    rdchk(ADR_DEVICE_REV, 8'ha5, "rev");
    $display("test registers done");
    wr(ADR_DIVISOR_LOW, 8'h02);
    period(8'h02, "div 2");
    wr(ADR_ENH_FEATURES, 8'h10);
    wr(ADR_MODEM_CONTROL, 8'h80);
    wr(ADR_DIVISOR_LOW, 8'h03);
    period(8'h0c, "div 3 prescaled");
    wr(ADR_MODEM_CONTROL, 8'h00);
    $display("test divisor done");
    wr(ADR_INT_ENABLE, 8'h28);
    chk(int_enable, 8'h28, "ier enh");
    wr(ADR_ENH_FEATURES, 8'h00);
    wr(ADR_INT_ENABLE, 8'hff);
    chk(int_enable, 8'h2f, "ier held");
    i_modem.set_lines(4'h0, 0);
    repeat (6) @(negedge clock);
    chk({7'h0, modem_irq}, 8'h01, "modem irq");
    rdchk(ADR_MODEM_STATUS, 8'hfb, "msr fall");
    rdchk(ADR_MODEM_STATUS, 8'hf0, "msr clear");
    chk({7'h0, modem_irq}, 8'h00, "irq clear");
    i_modem.set_lines(4'hf, 3);
    repeat (6) @(negedge clock);
    rdchk(ADR_MODEM_STATUS, 8'h0f, "msr rise");
    $display("test modem status done");
    // mcr bit 2 gated while the enhanced enable is off
    wr(ADR_MODEM_CONTROL, 8'h1f);
    chk(modem_ctrl, 8'h1b, "mcr held");
    rdchk(ADR_MODEM_STATUS, 8'hbb, "loopback");
    chk({6'h0, rts_n, dtr_n}, 8'h03, "loop pins");
    wr(ADR_ENH_FEATURES, 8'h10);
    wr(ADR_MODEM_CONTROL, 8'h1f);
    bus(1'b0, ADR_MODEM_STATUS, 8'h00);
    chk(q_r & 8'hf0, 8'hf0, "loop ring");
    wr(ADR_MODEM_CONTROL, 8'h03);
    @(negedge clock);
    chk({6'h0, i_modem.peer_req()}, 8'h03, "plain outputs");
    $display("test loopback done");
    for (int k = 0; k < 4; k++)
    begin
      wr(ADR_RESUME_FIRST + 6'(4 * k), 8'h11 + 8'(k));
      // select bits cleared before a new setting
      wr(ADR_ENH_FEATURES, 8'h00);
      wr(ADR_ENH_FEATURES, {4'h0, 2'(k), 2'b00});
      chk({6'h0, tx_flow_mode}, {6'h0, 2'(k)}, "tx mode");
    end
    chk(tx_pause_chars[7:0], 8'h14, "pause pair");
    chk(tx_resume_chars[15:8], 8'h11, "resume pair");
    for (int k = 0; k < 9; k++)
    begin
      // a repeated setting is kept between characters
      if (k == 0 || ef[k] != ef[k - 1])
        wr(ADR_ENH_FEATURES, 8'h00);
      if (k == 0 || ef[k] != ef[k - 1])
        wr(ADR_ENH_FEATURES, ef[k]);
      rx(ch[k], ex[k], "rx compare");
    end
    chk({6'h0, pause_irq, special_irq}, 8'h03, "rx irqs");
    bus(1'b0, ADR_INT_STATUS, 8'h00);
    chk(q_r & 8'h10, 8'h10, "special status");
    $display("test software flow done");
    @(posedge clock) tx_busy <= 1'b1;
    wr(ADR_ENH_FEATURES, 8'h80);
    repeat (6) @(negedge clock);
    chk({7'h0, tx_halt}, 8'h00, "char in progress");
    @(posedge clock) tx_busy <= 1'b0;
    repeat (3) @(negedge clock);
    chk({7'h0, tx_halt}, 8'h01, "halted");
    i_modem.set_lines(4'he, 0);
    repeat (6) @(negedge clock);
    chk({7'h0, tx_halt}, 8'h00, "resumed");
    wr(ADR_ENH_FEATURES, 8'h40);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock) rx_level <= lv[k];
      repeat (4) @(negedge clock);
      chk({6'h0, rts_n, rx_trig_irq}, {6'h0, rx2[k]}, "auto rts");
    end
    wr(ADR_MODEM_CONTROL, 8'h00);
    @(negedge clock);
    chk({7'h0, rts_n}, 8'h01, "rts bit off");
    $display("test hardware flow done");
    do_reset();
    chk({int_enable, modem_ctrl} == 16'h0 ? 8'h00 : 8'h01, 8'h00, "gated reset");
    chk({6'h0, fifo_ctrl_enh}, 8'h00, "fcr reset");
    rdchk(ADR_ENH_FEATURES, 8'h00, "efr reset");
    $display("test second reset done");
    print_verdict();
  end
endmodule
